// ### core/cpu_core_status_registers.sv
// Function
// (RQ1) Stack pointer resets to 0x07
// (RQ2) Push increments pointer, then stores byte
// (RQ3) Sixteen-bit pointer from low and high bytes
// (RQ4) Carry set on carry/borrow, else cleared
// (RQ5) Half carry on nibble carry/borrow, else cleared
// (RQ6) Status bits 5 and 1 software-only flags
// (RQ7) Bank bits pick one of four banks
// (RQ8) Software avoids bank change then register move
// (RQ9) Range error on overflow, big product, zero divide
// (RQ10) Those ops clear range error otherwise
// (RQ11) Status bit 0 is accumulator odd parity
// (RQ12) Software keeps reserved bits at zero
// (RQ13) Accumulator reachable by byte and bit
// (RQ14) Second accumulator for multiply/divide, bit access
// (RQ15) Other registers reset to zero
module cpu_core_status_registers
   import core_regs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire byte_req_s   byte_req,
   input  wire bit_req_s    bit_req,
   input  wire logic        push_go,
   input  wire logic [7:0]  push_data,
   input  wire alu_op_e     alu_op,
   input  wire logic [7:0]  alu_operand,
   output logic      [7:0]  byte_rdata,
   output logic             bit_rdata,
   output logic             stack_wr_en,
   output logic      [7:0]  stack_wr_addr,
   output logic      [7:0]  stack_wr_data,
   output logic      [15:0] indirect_pointer,
   output logic      [7:0]  bank_base,
   output logic      [7:0]  status_word,
   output logic      [7:0]  main_working_register,
   output logic      [7:0]  second_accumulator
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] stack_top_reg, stack_top_next;     // Stack-top pointer
   logic [7:0] ind_low_reg, ind_low_next;         // Pointer low byte
   logic [7:0] ind_high_reg, ind_high_next;       // Pointer high byte
   logic [7:0] status_reg, status_next;           // Status word
   logic [7:0] acc_reg, acc_next;                 // Accumulator
   logic [7:0] second_reg, second_next;           // Second accumulator
   alu_out_s   alu_res;                           // Arithmetic outcome
   logic       alu_go;                            // Arithmetic this cycle
   logic [7:0] bit_mask;                          // One-hot bit select
   logic       bit_to_status;                     // Bit write targets
   logic       bit_to_acc;
   logic       bit_to_second;

   assign alu_go = (alu_op != OP_NONE);
   assign bit_mask = 8'h01 << bit_req.addr[2:0];
   // Bit addresses share the upper five bits with the byte offset
   assign bit_to_status = bit_req.wr
                          && (bit_req.addr[7:3] == STATUS_OFS[7:3]);
   assign bit_to_acc    = bit_req.wr
                          && (bit_req.addr[7:3] == MAIN_WR_OFS[7:3]);
   assign bit_to_second = bit_req.wr
                          && (bit_req.addr[7:3] == SECOND_ACC_OFS[7:3]);

   // ---------------------------------------------------------------
   // Arithmetic unit
   // ---------------------------------------------------------------
   flag_alu alu_inst (
      .op       (alu_op),
      .acc      (acc_reg),
      .second   (second_reg),
      .carry_in (status_reg[CARRY_POS]),
      .operand  (alu_operand),
      .result   (alu_res)
   );

   // ---------------------------------------------------------------
   // Stack-top pointer
   // ---------------------------------------------------------------
   // Push outranks a software write in the same cycle
   always_comb begin
      stack_top_next = stack_top_reg;
      if (push_go) begin
         stack_top_next = stack_top_reg + 8'h01;           // RQ2
      end else if (byte_req.wr && byte_req.addr == STACK_TOP_OFS) begin
         stack_top_next = byte_req.wdata;
      end
   end

   // Pointer register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stack_top_reg <= STACK_TOP_RST;                   // RQ1
      end else begin
         stack_top_reg <= stack_top_next;
      end
   end

   // Stack store uses the already incremented address
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stack_wr_en   <= 1'b0;
         stack_wr_addr <= STACK_TOP_RST;
         stack_wr_data <= 8'h00;
      end else begin
         stack_wr_en <= push_go;                           // RQ2
         if (push_go) begin
            stack_wr_addr <= stack_top_reg + 8'h01;        // RQ2
            stack_wr_data <= push_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // Indirect pointer bytes
   // ---------------------------------------------------------------
   // Plain byte registers, no hardware update
   always_comb begin
      ind_low_next  = ind_low_reg;
      ind_high_next = ind_high_reg;
      if (byte_req.wr && byte_req.addr == IND_LOW_OFS) begin
         ind_low_next = byte_req.wdata;
      end
      if (byte_req.wr && byte_req.addr == IND_HIGH_OFS) begin
         ind_high_next = byte_req.wdata;
      end
   end

   // Pointer bytes and the joined address
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ind_low_reg      <= IND_LOW_RST;                  // RQ15
         ind_high_reg     <= IND_HIGH_RST;                 // RQ15
         indirect_pointer <= {IND_HIGH_RST, IND_LOW_RST};
      end else begin
         ind_low_reg      <= ind_low_next;
         ind_high_reg     <= ind_high_next;
         indirect_pointer <= {ind_high_next, ind_low_next}; // RQ3
      end
   end

   // ---------------------------------------------------------------
   // Accumulator and second accumulator
   // ---------------------------------------------------------------
   // Arithmetic outranks software; byte write then bit write
   always_comb begin
      acc_next    = acc_reg;
      second_next = second_reg;
      if (alu_go) begin
         acc_next    = alu_res.acc;                        // RQ13
         second_next = alu_res.second;                     // RQ14
      end else begin
         if (byte_req.wr && byte_req.addr == MAIN_WR_OFS) begin
            acc_next = byte_req.wdata;                     // RQ13
         end
         if (byte_req.wr && byte_req.addr == SECOND_ACC_OFS) begin
            second_next = byte_req.wdata;                  // RQ14
         end
         if (bit_to_acc) begin
            acc_next = bit_req.wdata ? (acc_next | bit_mask)
                                     : (acc_next & ~bit_mask); // RQ13
         end
         if (bit_to_second) begin
            second_next = bit_req.wdata ? (second_next | bit_mask)
                                        : (second_next & ~bit_mask); // RQ14
         end
      end
   end

   // Operand registers and their mirrors
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_reg               <= MAIN_WR_RST;             // RQ15
         second_reg            <= SECOND_ACC_RST;          // RQ15
         main_working_register <= MAIN_WR_RST;
         second_accumulator    <= SECOND_ACC_RST;
      end else begin
         acc_reg               <= acc_next;
         second_reg            <= second_next;
         main_working_register <= acc_next;
         second_accumulator    <= second_next;
      end
   end

   // ---------------------------------------------------------------
   // Status word
   // ---------------------------------------------------------------
   // Hardware owns carry, half carry and range error only during
   // arithmetic; user flags and bank bits stay with software
   always_comb begin
      status_next = status_reg;
      if (byte_req.wr && byte_req.addr == STATUS_OFS) begin
         status_next = byte_req.wdata;                     // RQ6
      end
      if (bit_to_status) begin
         status_next = bit_req.wdata ? (status_next | bit_mask)
                                     : (status_next & ~bit_mask); // RQ6
      end
      if (alu_go) begin
         status_next[CARRY_POS] = alu_res.carry;           // RQ4
         status_next[HALF_POS]  = alu_res.half;            // RQ5
         status_next[RANGE_POS] = alu_res.range_err;       // RQ9 RQ10
      end
      // Parity ignores writes and follows the next accumulator
      status_next[PARITY_POS] = ^acc_next;                 // RQ11
   end

   // Status word and the derived bank base
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_reg  <= STATUS_RST;                        // RQ15
         status_word <= STATUS_RST;
         bank_base   <= 8'h00;
      end else begin
         status_reg  <= status_next;
         status_word <= status_next;
         // Bank number times eight gives the first byte of the bank
         bank_base   <= {3'b000,
                         status_next[BANK_HIGH_POS:BANK_LOW_POS],
                         3'b000};                          // RQ7
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Registered one cycle after the address; unmapped reads zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byte_rdata <= UNMAPPED_DATA;
      end else begin
         case (byte_req.addr)
            STACK_TOP_OFS:  byte_rdata <= stack_top_reg;
            IND_LOW_OFS:    byte_rdata <= ind_low_reg;
            IND_HIGH_OFS:   byte_rdata <= ind_high_reg;
            STATUS_OFS:     byte_rdata <= status_reg;
            MAIN_WR_OFS:    byte_rdata <= acc_reg;          // RQ13
            SECOND_ACC_OFS: byte_rdata <= second_reg;
            default:        byte_rdata <= UNMAPPED_DATA;
         endcase
      end
   end

   // Bit reads from the three bit-addressable registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bit_rdata <= 1'b0;
      end else begin
         case (bit_req.addr[7:3])
            STATUS_OFS[7:3]:     bit_rdata <= status_reg[bit_req.addr[2:0]];
            MAIN_WR_OFS[7:3]:    bit_rdata <= acc_reg[bit_req.addr[2:0]];
            SECOND_ACC_OFS[7:3]: bit_rdata <= second_reg[bit_req.addr[2:0]];
            default:             bit_rdata <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   push_pre_increment_a: assert property ( // RQ2
      @(posedge clock) disable iff (rst)
      push_go |=> stack_wr_en && stack_wr_addr == stack_top_reg
                  && stack_top_reg == $past(stack_top_reg) + 8'h01)
      else $error("push did not pre-increment stack pointer");

   pointer_join_a: assert property ( // RQ3
      @(posedge clock) disable iff (rst)
      indirect_pointer == {ind_high_reg, ind_low_reg})
      else $error("indirect pointer differs from its bytes");

   add_carry_a: assert property ( // RQ4
      @(posedge clock) disable iff (rst)
      alu_op == OP_ADD |=> status_reg[CARRY_POS] ==
         (({1'b0, $past(acc_reg)} + {1'b0, $past(alu_operand)}) > 9'h0FF))
      else $error("carry wrong after add");

   mul_flags_a: assert property ( // RQ9
      @(posedge clock) disable iff (rst)
      alu_op == OP_MUL |=> !status_reg[CARRY_POS] && !status_reg[HALF_POS]
         && status_reg[RANGE_POS] == (second_reg != 8'h00))
      else $error("multiply flags wrong");

   div_zero_flag_a: assert property ( // RQ9
      @(posedge clock) disable iff (rst)
      alu_op == OP_DIV && second_reg == 8'h00
      |=> status_reg[RANGE_POS] && $stable(acc_reg))
      else $error("divide by zero not flagged");

   div_clear_range_a: assert property ( // RQ10
      @(posedge clock) disable iff (rst)
      alu_op == OP_DIV && second_reg != 8'h00
      |=> !status_reg[RANGE_POS])
      else $error("range error not cleared by divide");

   user_flags_kept_a: assert property ( // RQ6
      @(posedge clock) disable iff (rst)
      alu_go && !byte_req.wr && !bit_req.wr
      |=> $stable(status_reg[USER0_POS]) && $stable(status_reg[USER1_POS]))
      else $error("hardware changed a user flag");

   parity_track_a: assert property ( // RQ11
      @(posedge clock) disable iff (rst)
      status_reg[PARITY_POS] == ^acc_reg && status_word == status_reg)
      else $error("parity does not follow accumulator");

   bank_base_a: assert property ( // RQ7
      @(posedge clock) disable iff (rst)
      bank_base == ({6'h00, status_reg[BANK_HIGH_POS:BANK_LOW_POS]}
                    << BANK_SHIFT))
      else $error("bank base does not match bank bits");

endmodule

// ### core/core_regs_pkg.sv
package core_regs_pkg;

   // ---------------------------------------------------------------
   // Register offsets in the special-function space
   // ---------------------------------------------------------------
   localparam logic [7:0] STACK_TOP_OFS  = 8'h81; // Stack-top pointer
   localparam logic [7:0] IND_LOW_OFS    = 8'h82; // Pointer low byte
   localparam logic [7:0] IND_HIGH_OFS   = 8'h83; // Pointer high byte
   localparam logic [7:0] STATUS_OFS     = 8'hD0; // Status word
   localparam logic [7:0] MAIN_WR_OFS    = 8'hE0; // Accumulator
   localparam logic [7:0] SECOND_ACC_OFS = 8'hF0; // Second accumulator

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] STACK_TOP_RST  = 8'h07;
   localparam logic [7:0] IND_LOW_RST    = 8'h00;
   localparam logic [7:0] IND_HIGH_RST   = 8'h00;
   localparam logic [7:0] STATUS_RST     = 8'h00;
   localparam logic [7:0] MAIN_WR_RST    = 8'h00;
   localparam logic [7:0] SECOND_ACC_RST = 8'h00;

   // ---------------------------------------------------------------
   // Status word field positions
   // ---------------------------------------------------------------
   localparam int CARRY_POS     = 7; // carry_flag
   localparam int HALF_POS      = 6; // half_carry_flag
   localparam int USER0_POS     = 5; // user_flag_zero
   localparam int BANK_HIGH_POS = 4; // bank_select_high
   localparam int BANK_LOW_POS  = 3; // bank_select_low
   localparam int RANGE_POS     = 2; // signed_range_error_flag
   localparam int USER1_POS     = 1; // user_flag_one
   localparam int PARITY_POS    = 0; // Parity, read-only

   // Bank base is bank number times eight bytes
   localparam int BANK_SHIFT = 3;

   // Answer to an unmapped register read
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ---------------------------------------------------------------
   // Arithmetic operations that touch the flags
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_ADD  = 3'h1,
      OP_ADDC = 3'h2,
      OP_SUBB = 3'h3,
      OP_MUL  = 3'h4,
      OP_DIV  = 3'h5
   } alu_op_e;

   // Result of one arithmetic step
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] second;
      logic       carry;
      logic       half;
      logic       range_err;
   } alu_out_s;

   // Byte-wide register write request
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } byte_req_s;

   // Single-bit register write request
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       wdata;
   } bit_req_s;

endpackage

// ### core/flag_alu.sv
module flag_alu
   import core_regs_pkg::*;
(
   input  wire alu_op_e    op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] second,
   input  wire logic       carry_in,
   input  wire logic [7:0] operand,
   output alu_out_s        result
);

   // ---------------------------------------------------------------
   // Arithmetic and flag generation
   // ---------------------------------------------------------------
   logic [8:0]  wide;    // Byte result with carry or borrow
   logic [4:0]  nibble;  // Low nibble result with carry or borrow
   logic [15:0] product; // Full multiply result
   logic        cin;     // Carry used by this op

   // Purely combinational; the caller registers the outcome
   always_comb begin
      result  = '{acc: acc, second: second, carry: 1'b0,
                  half: 1'b0, range_err: 1'b0};
      cin     = (op == OP_ADDC || op == OP_SUBB) ? carry_in : 1'b0;
      wide    = 9'h000;
      nibble  = 5'h00;
      product = acc * second;
      case (op)
         OP_ADD, OP_ADDC: begin
            wide   = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
            nibble = {1'b0, acc[3:0]} + {1'b0, operand[3:0]}
                     + {4'h0, cin};
            result.acc       = wide[7:0];
            result.carry     = wide[8];        // RQ4
            result.half      = nibble[4];      // RQ5
            // Same-sign operands giving other-sign sum
            result.range_err = (acc[7] == operand[7])
                               && (wide[7] != acc[7]); // RQ9
         end
         OP_SUBB: begin
            wide   = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
            nibble = {1'b0, acc[3:0]} - {1'b0, operand[3:0]}
                     - {4'h0, cin};
            result.acc       = wide[7:0];
            result.carry     = wide[8];        // RQ4
            result.half      = nibble[4];      // RQ5
            result.range_err = (acc[7] != operand[7])
                               && (wide[7] != acc[7]); // RQ9
         end
         OP_MUL: begin
            // Low byte to accumulator, high byte to second
            result.acc       = product[7:0];
            result.second    = product[15:8];  // RQ14
            result.range_err = |product[15:8]; // RQ9
         end
         OP_DIV: begin
            // Divide by zero leaves both operands untouched
            if (second == 8'h00) begin
               result.range_err = 1'b1;        // RQ9
            end else begin
               result.acc    = acc / second;
               result.second = acc % second;   // RQ14
            end
         end
         default: begin
            result.acc = acc;
         end
      endcase
   end

endmodule

// ### verification/test_cpu_core_status_registers.sv
module test_cpu_core_status_registers
   import core_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic        clock = 1'b0;   // System clock, 8 ns
   logic        rst   = 1'b1;   // Async reset, active high
   byte_req_s   byte_req = '0;  // Byte register access
   bit_req_s    bit_req  = '0;  // Bit register access
   logic        push_go  = 1'b0;
   logic [7:0]  push_data = 8'h00;
   alu_op_e     alu_op = OP_NONE;
   logic [7:0]  alu_operand = 8'h00;
   logic [7:0]  byte_rdata, stack_wr_addr, stack_wr_data, bank_base;
   logic [7:0]  status_word, main_working_register, second_accumulator;
   logic        bit_rdata, stack_wr_en;
   logic [15:0] indirect_pointer;
   int          err_total = 0;  // Mismatches
   int          checks_done = 0; // Comparisons

   always #4 clock = ~clock;

   cpu_core_status_registers dut (
      .clock(clock), .rst(rst), .byte_req(byte_req), .bit_req(bit_req),
      .push_go(push_go), .push_data(push_data), .alu_op(alu_op),
      .alu_operand(alu_operand), .byte_rdata(byte_rdata),
      .bit_rdata(bit_rdata), .stack_wr_en(stack_wr_en),
      .stack_wr_addr(stack_wr_addr), .stack_wr_data(stack_wr_data),
      .indirect_pointer(indirect_pointer), .bank_base(bank_base),
      .status_word(status_word),
      .main_working_register(main_working_register),
      .second_accumulator(second_accumulator));

   // ---------------------------------------------------------------
   // Compare and bus tasks; all entered at a falling edge
   // ---------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %b want %b", $time, m, got, exp);
      end
   endtask

   // Strobe drops at the next falling edge; the idle cycle after it
   // keeps a back-to-back call from raising it in the same time step
   task automatic wr_byte(input logic [7:0] a, d);
      byte_req.addr = a;
      byte_req.wdata = d;
      byte_req.wr = 1'b1;
      @(negedge clock);
      byte_req.wr = 1'b0;
      @(negedge clock);
   endtask

   task automatic wr_bit(input logic [7:0] a, input logic d);
      bit_req.addr = a;
      bit_req.wdata = d;
      bit_req.wr = 1'b1;
      @(negedge clock);
      bit_req.wr = 1'b0;
      @(negedge clock);
   endtask

   task automatic rd_byte(input logic [7:0] a, exp, input string m);
      byte_req.addr = a;
      @(posedge clock);
      @(negedge clock);
      cmp_byte(byte_rdata, exp, m);
   endtask

   task automatic rd_bit(input logic [7:0] a, input logic exp);
      bit_req.addr = a;
      @(posedge clock);
      @(negedge clock);
      cmp_bit(bit_rdata, exp, "bit read");
   endtask

   // One arithmetic step, then flags carry, half, range
   task automatic alu(input alu_op_e op, input logic [7:0] o, res,
                      input logic c, h, r);
      alu_op = op;
      alu_operand = o;
      @(negedge clock);
      alu_op = OP_NONE;
      @(negedge clock);
      cmp_byte(main_working_register, res, "alu result");
      cmp_bit(status_word[CARRY_POS], c, "carry");
      cmp_bit(status_word[HALF_POS], h, "half carry");
      cmp_bit(status_word[RANGE_POS], r, "range error");
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (4) @(negedge clock);
      rst = 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      cmp_byte(stack_wr_addr, 8'h07, "stack after reset");
      rd_byte(STACK_TOP_OFS, 8'h07, "stack read");
      rd_byte(IND_LOW_OFS, 8'h00, "low read");
      rd_byte(IND_HIGH_OFS, 8'h00, "high read");
      rd_byte(STATUS_OFS, 8'h00, "status read");
      rd_byte(MAIN_WR_OFS, 8'h00, "main read");
      rd_byte(SECOND_ACC_OFS, 8'h00, "second read");
      rd_byte(8'h84, 8'h00, "unmapped read");
      $display("test reset done");
   endtask

   // Back-to-back pushes: pointer bumps before each store
   task automatic test_push();
      push_go = 1'b1;
      push_data = 8'h55;
      @(negedge clock);
      cmp_bit(stack_wr_en, 1'b1, "push 1 strobe");
      cmp_byte(stack_wr_addr, 8'h08, "push 1 addr");
      cmp_byte(stack_wr_data, 8'h55, "push 1 data");
      push_data = 8'hAA;
      @(negedge clock);
      push_go = 1'b0;
      cmp_byte(stack_wr_addr, 8'h09, "push 2 addr");
      cmp_byte(stack_wr_data, 8'hAA, "push 2 data");
      @(negedge clock);
      cmp_bit(stack_wr_en, 1'b0, "push strobe ends");
      rd_byte(STACK_TOP_OFS, 8'h09, "stack after pushes");
      $display("test push done");
   endtask

   task automatic test_pointer();
      wr_byte(IND_LOW_OFS, 8'h34);
      wr_byte(IND_HIGH_OFS, 8'h12);
      cmp_byte(indirect_pointer[15:8], 8'h12, "pointer high");
      cmp_byte(indirect_pointer[7:0], 8'h34, "pointer low");
      rd_byte(IND_HIGH_OFS, 8'h12, "high read");
      $display("test pointer done");
   endtask

   // No register move ever follows a bank change here, and every
   // status bit outside the bank field is written as zero
   task automatic test_bank();
      logic [1:0] code;
      for (int i = 0; i < 4; i++) begin
         code = i[1:0];
         wr_byte(STATUS_OFS, {3'h0, code, 3'h0});
         cmp_byte(bank_base, {3'h0, code, 3'h0}, "bank base");
      end
      $display("test bank done");
   endtask

   // Software flags survive arithmetic; parity bit rejects writes
   task automatic test_user_flags();
      wr_bit(8'hD5, 1'b1);
      wr_bit(8'hD1, 1'b1);
      wr_bit(8'hD0, 1'b1);
      cmp_bit(status_word[PARITY_POS], 1'b0, "parity not writable");
      alu(OP_ADD, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0);
      rd_bit(8'hD5, 1'b1);
      rd_bit(8'hD1, 1'b1);
      wr_bit(8'hD5, 1'b0);
      cmp_bit(status_word[USER0_POS], 1'b0, "flag zero cleared");
      cmp_bit(status_word[USER1_POS], 1'b1, "flag one kept");
      $display("test user flags done");
   endtask

   task automatic test_add();
      wr_byte(MAIN_WR_OFS, 8'h80);
      alu(OP_ADD, 8'h80, 8'h00, 1'b1, 1'b0, 1'b1);
      wr_byte(MAIN_WR_OFS, 8'h0F);
      alu(OP_ADD, 8'h01, 8'h10, 1'b0, 1'b1, 1'b0);
      alu(OP_SUBB, 8'h01, 8'h0F, 1'b0, 1'b1, 1'b0);
      alu(OP_SUBB, 8'h10, 8'hFF, 1'b1, 1'b0, 1'b0);
      alu(OP_ADDC, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
      wr_byte(MAIN_WR_OFS, 8'h80);
      alu(OP_SUBB, 8'h01, 8'h7E, 1'b0, 1'b1, 1'b1);
      $display("test add done");
   endtask

   task automatic test_mul_div();
      wr_byte(MAIN_WR_OFS, 8'h20);
      wr_byte(SECOND_ACC_OFS, 8'h10);
      alu(OP_MUL, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      cmp_byte(second_accumulator, 8'h02, "product high");
      wr_byte(MAIN_WR_OFS, 8'h07);
      wr_byte(SECOND_ACC_OFS, 8'h02);
      alu(OP_DIV, 8'h00, 8'h03, 1'b0, 1'b0, 1'b0);
      rd_byte(SECOND_ACC_OFS, 8'h01, "remainder");
      wr_byte(SECOND_ACC_OFS, 8'h00);
      alu(OP_DIV, 8'h00, 8'h03, 1'b0, 1'b0, 1'b1);
      $display("test mul div done");
   endtask

   // Parity follows byte and bit writes of the accumulator
   task automatic test_parity();
      wr_byte(MAIN_WR_OFS, 8'h07);
      cmp_bit(status_word[PARITY_POS], 1'b1, "odd parity");
      wr_bit(8'hE0, 1'b0);
      cmp_byte(main_working_register, 8'h06, "main bit write");
      cmp_bit(status_word[PARITY_POS], 1'b0, "even parity");
      rd_bit(8'hE1, 1'b1);
      wr_bit(8'hF7, 1'b1);
      cmp_byte(second_accumulator, 8'h80, "second bit write");
      rd_bit(8'hF7, 1'b1);
      $display("test parity done");
   endtask

   // ---------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Tests need well under 300 cycles; allow far more
   initial begin
      #50000;
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      do_reset();
      test_reset();
      test_push();
      test_pointer();
      test_bank();
      test_user_flags();
      test_add();
      test_mul_div();
      test_parity();
      // Second reset in mid-run must restore every value
      do_reset();
      test_reset();
      print_verdict();
   end
endmodule
